// *** inc/wwd_pkg.sv ***
// Constants and types for the window watchdog with reset and arm gating.
// =============================================================================
// =============================================================================
package wwd_pkg;

   // =========================================================================
   // Timing
   // =========================================================================
   localparam int unsigned CLOCK_HZ          = 20000000;
   localparam int unsigned RESET_PULSE_US    = 1000;
   localparam int unsigned RESET_PULSE_COUNT = RESET_PULSE_US * (CLOCK_HZ / 1000000);
   localparam int unsigned WINDOW_MIN_US     = 10000;
   localparam int unsigned WINDOW_MAX_US     = 20000;
   localparam int unsigned POWER_ON_US       = 2000;
   localparam int unsigned WINDOW_MIN_COUNT  = WINDOW_MIN_US * (CLOCK_HZ / 1000000);
   localparam int unsigned WINDOW_MAX_COUNT  = WINDOW_MAX_US * (CLOCK_HZ / 1000000);
   localparam int unsigned POWER_ON_COUNT    = POWER_ON_US * (CLOCK_HZ / 1000000);
   localparam int unsigned TIMER_WIDTH       = 24;

   // =========================================================================
   // Reset values and encodings
   // =========================================================================
   localparam logic        ERROR_FLAG_RESET  = 1'h0;
   localparam logic        LOCKOUT_RESET     = 1'h0;
   localparam logic        POLARITY_RESET    = 1'h0;

   // Refresh state machine states.
   typedef enum logic [1:0]
   {
      WWD_IDLE     = 2'b00,
      WWD_ACTIVE   = 2'b01,
      WWD_OVERRIDE = 2'b10,
      WWD_TEST     = 2'b11
   } wwd_state_t;

endpackage : wwd_pkg

// *** hw/wwd_pulse_timer.sv ***
// Reloadable down counter that holds a busy level for a set number of cycles.
`timescale 1ns/1ns
module wwd_pulse_timer
#(
   parameter int unsigned WIDTH = 24
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // Control
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] load,
   // Status
   output logic                  busy
);

   logic [WIDTH-1:0] count;

   // =========================================================================
   // Counter
   // =========================================================================
   // A start reloads the count; busy stays high until it runs out.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         count <= '0;
      end
      else if (start)
      begin
         count <= load;
      end
      else if (count != '0)
      begin
         count <= count - WIDTH'(1);
      end
   end

   assign busy = (count != '0);

endmodule : wwd_pulse_timer

// *** hw/wwd_watchdog.sv ***
// Window watchdog: reset generation, refresh checking and deploy output gating.
`timescale 1ns/1ns
module wwd_watchdog
#(
   parameter int unsigned POWER_ON_CYCLES   = wwd_pkg::POWER_ON_COUNT,
   parameter int unsigned WINDOW_MIN_CYCLES = wwd_pkg::WINDOW_MIN_COUNT,
   parameter int unsigned WINDOW_MAX_CYCLES = wwd_pkg::WINDOW_MAX_COUNT,
   parameter int unsigned RESET_CYCLES      = wwd_pkg::RESET_PULSE_COUNT,
   parameter logic        HIGH_POLARITY     = 1'h1
)
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // Reset sources, active high when demanding reset (asynchronous)
   input  wire logic main_supply_fault,
   input  wire logic core_supply_fault,
   input  wire logic open_ground_fault,
   input  wire logic bandgap_fault,
   input  wire logic analog_reset,
   input  wire logic safing_fsm_reset,
   input  wire logic refresh_fsm_reset,
   // Host commands from logic on this clock; polarity and arm are levels, the others one-cycle pulses
   input  wire logic refresh_command,
   input  wire logic refresh_polarity,
   input  wire logic lockout_bypass_test_command,
   input  wire logic override_request,
   input  wire logic arm_request,
   // Outputs
   output logic      reset_out_n,
   output logic      core_reset,
   output logic      watchdog_error_flag,
   output logic      deploy_lockout,
   output logic      deploy_enable_pos,
   output logic      deploy_enable_neg,
   output logic      deploy_enable_oe,
   output logic [1:0] watchdog_state
);

   // =========================================================================
   // Reset release and input synchronisers
   // =========================================================================
   logic       rst_meta;
   logic       rst_sync;
   logic [6:0] sync_a;
   logic [6:0] sync_b;
   logic [6:0] raw_in;

   // Release the asynchronous reset through two flip-flops.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'h0;
         rst_sync <= 1'h0;
      end
      else
      begin
         rst_meta <= 1'h1;
         rst_sync <= rst_meta;
      end
   end

   assign raw_in = {main_supply_fault, core_supply_fault, open_ground_fault, bandgap_fault,
                    analog_reset, safing_fsm_reset, refresh_fsm_reset};

   // Pins pass two flip-flops; only the second stage is read.
   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         sync_a <= 7'h7F;
         sync_b <= 7'h7F;
      end
      else
      begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   logic s_main;
   logic s_core;
   logic s_gnd;
   logic s_bg;
   logic s_analog;
   logic s_safing;
   logic s_wsm;
   assign {s_main, s_core, s_gnd, s_bg, s_analog, s_safing, s_wsm} = sync_b;

   // =========================================================================
   // Power-on delay
   // =========================================================================
   logic [wwd_pkg::TIMER_WIDTH-1:0] por_count;
   logic                            por_done;

   // power-on delay
   // The delay restarts whenever the main supply leaves its valid range.
   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         por_count <= '0;
         por_done  <= 1'h0;
      end
      else if (s_main)
      begin
         por_count <= '0;
         por_done  <= 1'h0;
      end
      else if (por_count >= wwd_pkg::TIMER_WIDTH'(POWER_ON_CYCLES - 1))
      begin
         por_done <= 1'h1;
      end
      else
      begin
         por_count <= por_count + wwd_pkg::TIMER_WIDTH'(1);
      end
   end

   // =========================================================================
   // Refresh window checking
   // =========================================================================
   wwd_pkg::wwd_state_t             state;
   wwd_pkg::wwd_state_t             next_state;
   logic [wwd_pkg::TIMER_WIDTH-1:0] window_count;
   logic                            last_polarity;
   logic                            test_armed;
   logic                            refresh_ok;
   logic                            refresh_bad;
   logic                            timeout;
   logic                            wd_error;
   logic                            wd_reset_busy;
   logic                            wsm_clear;
   logic                            running;

   // The refresh machine and its flags only run while reset is released.
   assign wsm_clear = s_wsm || !por_done;
   assign running   = (state != wwd_pkg::WWD_IDLE);

   // error detection
   // Polarity must alternate and the gap must sit inside the window.
   assign refresh_ok  = refresh_command && (refresh_polarity != last_polarity)
                        && (window_count > wwd_pkg::TIMER_WIDTH'(WINDOW_MIN_CYCLES))
                        && (window_count < wwd_pkg::TIMER_WIDTH'(WINDOW_MAX_CYCLES));
   assign refresh_bad = refresh_command && !refresh_ok;
   assign timeout     = (window_count >= wwd_pkg::TIMER_WIDTH'(WINDOW_MAX_CYCLES));
   assign wd_error    = running && (state != wwd_pkg::WWD_OVERRIDE)
                        && (refresh_bad || timeout);

   // Time since the last refresh; restarts on every refresh command.
   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         window_count  <= '0;
         last_polarity <= wwd_pkg::POLARITY_RESET;
      end
      else if (wsm_clear)
      begin
         window_count  <= '0;
         last_polarity <= wwd_pkg::POLARITY_RESET;
      end
      else if (refresh_command)
      begin
         window_count  <= '0;
         last_polarity <= refresh_polarity;
      end
      // A missed refresh is one failure; a new window starts at once, so one
      // timeout gives one reset pulse and cannot spill into the next state.
      else if (timeout)
      begin
         window_count <= '0;
      end
      else if (running)
      begin
         window_count <= window_count + wwd_pkg::TIMER_WIDTH'(1);
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         wwd_pkg::WWD_IDLE:
         begin
            if (override_request)
               next_state = wwd_pkg::WWD_OVERRIDE;
            else if (refresh_command)
               next_state = wwd_pkg::WWD_ACTIVE;
         end
         wwd_pkg::WWD_ACTIVE:
         begin
            if (lockout_bypass_test_command)
               next_state = wwd_pkg::WWD_TEST;
         end
         wwd_pkg::WWD_TEST:
         begin
            if (refresh_command || wd_error)
               next_state = wwd_pkg::WWD_ACTIVE;
         end
         wwd_pkg::WWD_OVERRIDE:
         begin
            next_state = wwd_pkg::WWD_OVERRIDE;
         end
         default:
         begin
            next_state = wwd_pkg::WWD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         state <= wwd_pkg::WWD_IDLE;
      end
      else if (wsm_clear)
      begin
         state <= wwd_pkg::WWD_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign test_armed = (state == wwd_pkg::WWD_TEST);

   wwd_pulse_timer #(.WIDTH(wwd_pkg::TIMER_WIDTH)) u_reset_pulse
   (
      .clock  (clock),
      .resetn (rst_sync),
      .start  (wd_error),
      .load   (wwd_pkg::TIMER_WIDTH'(RESET_CYCLES)),
      .busy   (wd_reset_busy)
   );

   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         watchdog_error_flag <= wwd_pkg::ERROR_FLAG_RESET;
      end
      else if (wsm_clear)
      begin
         watchdog_error_flag <= wwd_pkg::ERROR_FLAG_RESET;
      end
      else if (wd_error)
      begin
         watchdog_error_flag <= 1'h1;
      end
      else if (refresh_ok)
      begin
         watchdog_error_flag <= 1'h0;
      end
   end

   // =========================================================================
   // Reset outputs
   // =========================================================================
   logic system_reset;

   assign system_reset = !por_done || s_core || s_gnd || s_bg || wd_error || wd_reset_busy;

   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         reset_out_n <= 1'h0;
         core_reset  <= 1'h1;
      end
      else
      begin
         reset_out_n <= !system_reset;
         core_reset  <= s_core || s_bg || s_gnd;
      end
   end

   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         deploy_lockout <= wwd_pkg::LOCKOUT_RESET;
      end
      else if (wsm_clear)
      begin
         deploy_lockout <= wwd_pkg::LOCKOUT_RESET;
      end
      else if (wd_error && (state == wwd_pkg::WWD_ACTIVE) && !test_armed)
      begin
         deploy_lockout <= 1'h1;
      end
   end

   // =========================================================================
   // Arming gate
   // =========================================================================
   logic pass_arm;

   assign pass_arm = (state == wwd_pkg::WWD_OVERRIDE)
                     || ((state == wwd_pkg::WWD_ACTIVE) && !s_safing && !deploy_lockout
                         && !system_reset);

   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         deploy_enable_oe  <= 1'h0;
         deploy_enable_pos <= 1'h0;
         deploy_enable_neg <= 1'h1;
         watchdog_state    <= 2'h0;
      end
      else
      begin
         deploy_enable_oe  <= pass_arm && !s_analog;
         deploy_enable_pos <= arm_request;
         deploy_enable_neg <= !arm_request;
         watchdog_state    <= next_state;
      end
   end

   // =========================================================================
   // Checks
   // =========================================================================
   sequence s_fail;
      wd_error && !wsm_clear;
   endsequence

   a_error_sets_flag: assert property (@(posedge clock) disable iff (!rst_sync)
      s_fail |=> watchdog_error_flag)
      else $error("Watchdog error did not set the flag.");

   a_error_resets_out: assert property (@(posedge clock) disable iff (!rst_sync)
      s_fail |=> ##1 !reset_out_n [*8])
      else $error("Watchdog error did not hold reset low.");

   a_idle_floats: assert property (@(posedge clock) disable iff (!rst_sync)
      (state == wwd_pkg::WWD_IDLE) |=> !deploy_enable_oe)
      else $error("Deploy outputs driven before first refresh.");

   a_analog_floats: assert property (@(posedge clock) disable iff (!rst_sync)
      s_analog |=> !deploy_enable_oe)
      else $error("Deploy outputs driven during analog reset.");

   a_clear_idle: assert property (@(posedge clock) disable iff (!rst_sync)
      wsm_clear |=> (state == wwd_pkg::WWD_IDLE) && !watchdog_error_flag && !deploy_lockout)
      else $error("Machine reset did not clear state and flags.");

   a_ok_clears: assert property (@(posedge clock) disable iff (!rst_sync)
      (refresh_ok && !wd_error && !wsm_clear) |=> !watchdog_error_flag)
      else $error("Correct refresh did not clear the flag.");

   a_test_no_lock: assert property (@(posedge clock) disable iff (!rst_sync)
      (test_armed && !deploy_lockout && !wsm_clear) |=> !deploy_lockout)
      else $error("Error in test state set the lockout.");

   a_first_refresh: assert property (@(posedge clock) disable iff (!rst_sync)
      ((state == wwd_pkg::WWD_IDLE) && refresh_command && !override_request && !wsm_clear)
      |=> (state == wwd_pkg::WWD_ACTIVE))
      else $error("First refresh did not start the machine.");

   a_override_ok: assert property (@(posedge clock) disable iff (!rst_sync)
      (state == wwd_pkg::WWD_OVERRIDE) |-> !wd_error)
      else $error("Error raised in override state.");

endmodule : wwd_watchdog

// *** sim/wwd_host_model.sv ***
// Host model that issues refresh, test and override commands to the watchdog.
`timescale 1ns/1ns
module wwd_host_model
(
   // Clock
   input  wire logic clock,
   // Commands towards the watchdog
   output logic      refresh_command,
   output logic      refresh_polarity,
   output logic      lockout_bypass_test_command,
   output logic      override_request
);
   // =========================================================================
   // Command tasks
   // =========================================================================
   logic last_pol;

   // Idle lines at time zero; the polarity line carries no meaning yet.
   initial
   begin
      refresh_command = 1'h0;
      refresh_polarity = 1'h1;
      lockout_bypass_test_command = 1'h0;
      override_request = 1'h0;
      last_pol = 1'h0;
   end

   // One refresh pulse; once released the polarity line shows the inverse.
   // polarity per refresh
   task automatic refresh(input logic pol);
      @(negedge clock);
      refresh_command <= 1'h1;
      refresh_polarity <= pol;
      last_pol = pol;
      @(negedge clock);
      refresh_command <= 1'h0;
      refresh_polarity <= ~pol;
   endtask : refresh

   // A correct host always flips the polarity of the previous refresh.
   // alternating polarity
   task automatic refresh_next();
      refresh(~last_pol);
   endtask : refresh_next

   // One-cycle test command, meant for the current window only.
   // test in window
   task automatic test_cmd();
      @(negedge clock);
      lockout_bypass_test_command <= 1'h1;
      @(negedge clock);
      lockout_bypass_test_command <= 1'h0;
   endtask : test_cmd

   // One-cycle override request, meant right after a machine reset.
   // override entry
   task automatic override_cmd();
      @(negedge clock);
      override_request <= 1'h1;
      @(negedge clock);
      override_request <= 1'h0;
   endtask : override_cmd
endmodule : wwd_host_model

// *** sim/wwd_watchdog_tb.sv ***
// Self-checking testbench for the window watchdog with arm gating.
`timescale 1ns/1ns
module wwd_watchdog_tb;
   // =========================================================================
   // Signals
   // =========================================================================
   localparam int POR = 8;
   localparam int WMIN = 20;
   localparam int WMAX = 40;
   localparam int RST = 10;
   logic       clock, resetn, analog_reset, safing_fsm_reset, refresh_fsm_reset;
   logic       arm_request, refresh_command, refresh_polarity;
   logic       lockout_bypass_test_command, override_request;
   logic [3:0] fault;
   logic       reset_out_n, core_reset, watchdog_error_flag, deploy_lockout;
   logic       deploy_enable_pos, deploy_enable_neg, deploy_enable_oe;
   logic [1:0] watchdog_state;
   int         n_mismatch, checked, cycles, n, i, k;

   wwd_watchdog #(.POWER_ON_CYCLES(POR), .WINDOW_MIN_CYCLES(WMIN),
      .WINDOW_MAX_CYCLES(WMAX), .RESET_CYCLES(RST)) DUT
   (
      .clock(clock), .resetn(resetn),
      .main_supply_fault(fault[0]), .core_supply_fault(fault[1]),
      .open_ground_fault(fault[2]), .bandgap_fault(fault[3]),
      .analog_reset(analog_reset), .safing_fsm_reset(safing_fsm_reset),
      .refresh_fsm_reset(refresh_fsm_reset), .refresh_command(refresh_command),
      .refresh_polarity(refresh_polarity),
      .lockout_bypass_test_command(lockout_bypass_test_command),
      .override_request(override_request), .arm_request(arm_request),
      .reset_out_n(reset_out_n), .core_reset(core_reset),
      .watchdog_error_flag(watchdog_error_flag), .deploy_lockout(deploy_lockout),
      .deploy_enable_pos(deploy_enable_pos), .deploy_enable_neg(deploy_enable_neg),
      .deploy_enable_oe(deploy_enable_oe), .watchdog_state(watchdog_state)
   );

   wwd_host_model host
   (
      .clock(clock), .refresh_command(refresh_command),
      .refresh_polarity(refresh_polarity),
      .lockout_bypass_test_command(lockout_bypass_test_command),
      .override_request(override_request)
   );

   // =========================================================================
   // Clock, timeout and helpers
   // =========================================================================
   // Free running 20 MHz clock.
   initial
   begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end

   // A hang ends the run as a failure.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic step(input int c);
      repeat (c) @(negedge clock);
   endtask : step

   // Waits, bounded, for the reset output to be released.
   task automatic wait_release();
      for (int j = 0; j < 100 && reset_out_n !== 1'h1; j++) @(negedge clock);
      check("reset_out_n", reset_out_n, 8'h01);
   endtask : wait_release

   // Holds the machine reset long enough to pass its synchroniser.
   task automatic fsm_reset();
      @(negedge clock);
      refresh_fsm_reset <= 1'h1;
      step(3);
      refresh_fsm_reset <= 1'h0;
      step(4);
   endtask : fsm_reset

   task automatic tally_and_finish();
      if (n_mismatch == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // =========================================================================
   // Test sequence
   // =========================================================================
   initial
   begin
      resetn = 1'h0;
      fault = 4'h1;
      {analog_reset, safing_fsm_reset, refresh_fsm_reset, arm_request} = 4'h0;
      step(20);
      check("reset_out_n", reset_out_n, 8'h00);
      check("flag", watchdog_error_flag, 8'h00);
      check("state", watchdog_state, 8'h00);
      check("oe", deploy_enable_oe, 8'h00);
      resetn <= 1'h1;
      step(30);
      check("reset_out_n", reset_out_n, 8'h00);
      fault <= 4'h0;
      wait_release();
      for (k = 0; k < 4; k++)
      begin
         fault[k] <= 1'h1;
         step(4);
         check("reset_out_n", reset_out_n, 8'h00);
         check("core_reset", core_reset, k > 0);
         fault <= 4'h0;
         wait_release();
      end
      arm_request <= 1'h1;
      step(4);
      check("oe", deploy_enable_oe, 8'h00);
      // First refresh, then gating by safing and analog resets.
      host.refresh(1'h1);
      step(3);
      check("state", watchdog_state, 8'h01);
      check("oe", deploy_enable_oe, 8'h01);
      check("pos", deploy_enable_pos, 8'h01);
      check("neg", deploy_enable_neg, 8'h00);
      safing_fsm_reset <= 1'h1;
      step(4);
      check("oe", deploy_enable_oe, 8'h00);
      check("state", watchdog_state, 8'h01);
      safing_fsm_reset <= 1'h0;
      analog_reset <= 1'h1;
      step(4);
      check("oe", deploy_enable_oe, 8'h00);
      analog_reset <= 1'h0;
      step(17);
      host.refresh_next();
      step(3);
      check("flag", watchdog_error_flag, 8'h00);
      host.override_cmd();
      step(2);
      check("state", watchdog_state, 8'h01);
      // Repeated polarity inside the window.
      step(21);
      host.refresh(host.last_pol);
      n = 0;
      for (i = 0; i < 25; i++)
      begin
         if (reset_out_n === 1'h0) n++;
         @(negedge clock);
      end
      check("reset_len", n[7:0], 8'(RST + 1));
      check("flag", watchdog_error_flag, 8'h01);
      check("lockout", deploy_lockout, 8'h01);
      check("oe", deploy_enable_oe, 8'h00);
      step(8);
      check("flag", watchdog_error_flag, 8'h01);
      fsm_reset();
      check("state", watchdog_state, 8'h00);
      check("flag", watchdog_error_flag, 8'h00);
      check("lockout", deploy_lockout, 8'h00);
      // Refresh before the minimum window time.
      host.refresh(1'h1);
      host.refresh_next();
      step(2);
      check("flag", watchdog_error_flag, 8'h01);
      fsm_reset();
      // Missing refresh.
      host.refresh(1'h0);
      step(45);
      check("flag", watchdog_error_flag, 8'h01);
      check("lockout", deploy_lockout, 8'h01);
      fsm_reset();
      host.test_cmd();
      step(3);
      check("state", watchdog_state, 8'h00);
      // Test command covers an error in the same window.
      host.refresh(1'h1);
      step(5);
      host.test_cmd();
      step(2);
      check("state", watchdog_state, 8'h03);
      step(20);
      host.refresh(1'h1);
      step(3);
      check("flag", watchdog_error_flag, 8'h01);
      check("lockout", deploy_lockout, 8'h00);
      fsm_reset();
      // Override passes arm despite safing reset and ignores errors.
      host.override_cmd();
      step(3);
      check("state", watchdog_state, 8'h02);
      safing_fsm_reset <= 1'h1;
      step(4);
      check("oe", deploy_enable_oe, 8'h01);
      safing_fsm_reset <= 1'h0;
      arm_request <= 1'h0;
      host.refresh(1'h0);
      step(3);
      check("flag", watchdog_error_flag, 8'h00);
      check("oe", deploy_enable_oe, 8'h01);
      check("pos", deploy_enable_pos, 8'h00);
      check("neg", deploy_enable_neg, 8'h01);
      tally_and_finish();
   end
endmodule : wwd_watchdog_tb
